// File: core/ckg_core.v
// serial configuration slave and glitch-free stop logic for differential output pairs
`include "ckg_regs.vh"
// =============================================================
module ckg_core #(
  parameter NUM_PAIRS = 8,
  parameter [7:0] MAKER_ID = `CKG_RST_MAKER_ID
) (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire i_scl,
  input wire i_sda,
  output reg o_sda_out,
  output reg o_sda_oe,
  input wire [1:0] i_output_stop_request_n,
  input wire i_pair_ref_edge_clock,
  output reg [NUM_PAIRS-1:0] o_pair_true_out,
  output reg [NUM_PAIRS-1:0] o_pair_comp_out,
  output reg [NUM_PAIRS-1:0] o_pair_output_oe,
  output reg [7:0] o_control_byte_zero,
  output reg [7:0] o_control_byte_one,
  output reg [7:0] o_control_byte_two,
  output reg [7:0] o_control_byte_three,
  output reg [7:0] o_control_byte_six
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_CMD = 3'h2;
  localparam [2:0] ST_WR = 3'h3;
  localparam [2:0] ST_RD = 3'h4;
  localparam [7:0] BLK_COUNT = `CKG_BLK_COUNT;

  // =============================================================
  // pin synchronisers: first stage feeds only the second
  reg scl_m_r;
  reg scl_s_r;
  reg scl_d_r;
  reg sda_m_r;
  reg sda_s_r;
  reg sda_d_r;
  reg ref_m_r;
  reg ref_s_r;
  reg ref_d_r;
  reg [1:0] req_m_r;
  reg [1:0] req_s_r;

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
      ref_m_r <= 1'b0;
      ref_s_r <= 1'b0;
      ref_d_r <= 1'b0;
      // same level as the debounced state after reset, so no false request
      req_m_r <= 2'h0;
      req_s_r <= 2'h0;
    end else begin
      scl_m_r <= i_scl;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= i_sda;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
      ref_m_r <= i_pair_ref_edge_clock;
      ref_s_r <= ref_m_r;
      ref_d_r <= ref_s_r;
      req_m_r <= i_output_stop_request_n;
      req_s_r <= req_m_r;
    end
  end

  wire scl_rise = scl_s_r & ~scl_d_r;
  wire scl_fall = ~scl_s_r & scl_d_r;
  wire bus_start = scl_s_r & scl_d_r & ~sda_s_r & sda_d_r;
  wire bus_stop = scl_s_r & scl_d_r & sda_s_r & ~sda_d_r;
  wire ref_rise = ref_s_r & ~ref_d_r;
  wire ref_fall = ~ref_s_r & ref_d_r;

  // =============================================================
  // configuration registers
  reg [7:0] stop_sel4_r;
  reg [7:0] stop_sel5_r;
  reg [4:0] ptr_r;
  reg [7:0] rdata;

  always @* begin
    case (ptr_r)
      `CKG_OFS_CTRL0: rdata = o_control_byte_zero;
      `CKG_OFS_CTRL1: rdata = o_control_byte_one;
      `CKG_OFS_CTRL2: rdata = o_control_byte_two;
      `CKG_OFS_CTRL3: rdata = o_control_byte_three;
      `CKG_OFS_STOPSEL4: rdata = stop_sel4_r;
      `CKG_OFS_STOPSEL5: rdata = stop_sel5_r;
      `CKG_OFS_CTRL6: rdata = o_control_byte_six;
      `CKG_OFS_MAKER_ID: rdata = MAKER_ID;
      default: rdata = 8'h00;
    endcase
  end

  // =============================================================
  // serial slave
  reg [2:0] state_r;
  reg [3:0] bit_r;
  reg [7:0] shreg_r;
  reg [7:0] tx_r;
  reg cmd_seen_r;
  reg blk_r;
  reg cnt_phase_r;
  reg rd_first_r;
  reg mack_n_r;
  reg wr_en;

  // a write lands only on a fully received data byte, on the scl fall that starts its acknowledge
  always @* begin
    wr_en = scl_fall & (bit_r == 4'h7) & (state_r == ST_WR) & ~cnt_phase_r;
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_control_byte_zero <= `CKG_RST_CTRL0;
      o_control_byte_one <= `CKG_RST_CTRL1;
      o_control_byte_two <= `CKG_RST_CTRL2;
      o_control_byte_three <= `CKG_RST_CTRL3;
      stop_sel4_r <= `CKG_RST_STOPSEL4;
      stop_sel5_r <= `CKG_RST_STOPSEL5;
      o_control_byte_six <= `CKG_RST_CTRL6;
    end else if (wr_en) begin
      case (ptr_r)
        `CKG_OFS_CTRL0: o_control_byte_zero <= shreg_r;
        `CKG_OFS_CTRL1: o_control_byte_one <= shreg_r;
        `CKG_OFS_CTRL2: o_control_byte_two <= shreg_r;
        `CKG_OFS_CTRL3: o_control_byte_three <= shreg_r;
        `CKG_OFS_STOPSEL4: stop_sel4_r <= shreg_r;
        `CKG_OFS_STOPSEL5: stop_sel5_r <= shreg_r;
        `CKG_OFS_CTRL6: o_control_byte_six <= shreg_r;
        default: o_control_byte_six <= o_control_byte_six;
      endcase
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
      bit_r <= 4'h0;
      shreg_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 5'h00;
      cmd_seen_r <= 1'b0;
      blk_r <= 1'b0;
      cnt_phase_r <= 1'b0;
      rd_first_r <= 1'b0;
      mack_n_r <= 1'b1;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (bus_start) begin
      // repeated start keeps the command context for the read phase
      state_r <= ST_ADDR;
      // the scl fall that ends the start wraps this to bit zero
      bit_r <= 4'hf;
      o_sda_oe <= 1'b0;
    end else if (bus_stop) begin
      state_r <= ST_IDLE;
      cmd_seen_r <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (state_r != ST_IDLE) begin
      if (scl_rise) begin
        if (bit_r != 4'h8) begin
          shreg_r <= {shreg_r[6:0], sda_s_r};
        end else begin
          mack_n_r <= sda_s_r;
        end
      end
      if (scl_fall) begin
        if (bit_r == 4'h7) begin
          bit_r <= 4'h8;
          case (state_r)
            ST_ADDR: begin
              if (shreg_r == `CKG_SLV_ADDR_WR) begin
                o_sda_oe <= 1'b1;
                state_r <= ST_CMD;
              end else if (shreg_r == `CKG_SLV_ADDR_RD && cmd_seen_r) begin
                o_sda_oe <= 1'b1;
                state_r <= ST_RD;
                rd_first_r <= 1'b1;
              end else begin
                state_r <= ST_IDLE;
              end
            end
            ST_CMD: begin
              if (shreg_r[`CKG_CMD_CS_HI:`CKG_CMD_CS_LO] == `CKG_CMD_CS_VAL) begin
                o_sda_oe <= 1'b1;
                blk_r <= ~shreg_r[`CKG_CMD_BYTE_BIT];
                cnt_phase_r <= ~shreg_r[`CKG_CMD_BYTE_BIT];
                // block transfers always start at byte zero
                ptr_r <= shreg_r[`CKG_CMD_BYTE_BIT] ?
                  shreg_r[`CKG_CMD_IDX_HI:`CKG_CMD_IDX_LO] : `CKG_OFS_CTRL0;
                cmd_seen_r <= 1'b1;
                state_r <= ST_WR;
              end else begin
                state_r <= ST_IDLE;
              end
            end
            ST_WR: begin
              o_sda_oe <= 1'b1;
              if (cnt_phase_r) begin
                cnt_phase_r <= 1'b0;
              end else if (ptr_r != 5'h1f) begin
                ptr_r <= ptr_r + 5'h01;
              end
            end
            default: o_sda_oe <= 1'b0;
          endcase
        end else if (bit_r == 4'h8) begin
          bit_r <= 4'h0;
          if (state_r == ST_RD && (rd_first_r || !mack_n_r)) begin
            rd_first_r <= 1'b0;
            if (cnt_phase_r) begin
              // block read leads with its byte count
              tx_r <= BLK_COUNT;
              o_sda_oe <= ~BLK_COUNT[7];
              cnt_phase_r <= 1'b0;
            end else begin
              tx_r <= rdata;
              o_sda_oe <= ~rdata[7];
              if (ptr_r != 5'h1f) begin
                ptr_r <= ptr_r + 5'h01;
              end
            end
          end else begin
            o_sda_oe <= 1'b0;
            if (state_r == ST_RD) begin
              state_r <= ST_IDLE;
            end
          end
        end else begin
          bit_r <= bit_r + 4'h1;
          if (state_r == ST_RD) begin
            tx_r <= {tx_r[6:0], 1'b0};
            o_sda_oe <= ~tx_r[6];
          end
        end
      end
    end
  end

  // =============================================================
  // stop request debounce on reference clock rising edges
  reg [1:0] req_smp_r;
  reg [1:0] req_valid_n_r;

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      req_smp_r <= 2'h0;
      req_valid_n_r <= 2'h0;
    end else if (ref_rise) begin
      req_smp_r <= req_s_r;
      // a level counts only once two successive edges agree
      req_valid_n_r <= (req_valid_n_r & (req_smp_r ^ req_s_r)) |
        (req_s_r & ~(req_smp_r ^ req_s_r));
    end
  end

  // =============================================================
  // pair gating
  wire drive_mode = o_control_byte_six[`CKG_DRIVE_MODE_BIT];
  wire [NUM_PAIRS-1:0] sel0 = stop_sel4_r[NUM_PAIRS-1:0];
  wire [NUM_PAIRS-1:0] sel1 = stop_sel5_r[NUM_PAIRS-1:0];
  wire [NUM_PAIRS-1:0] stop_want = ({NUM_PAIRS{req_valid_n_r[0]}} & sel0) |
    ({NUM_PAIRS{req_valid_n_r[1]}} & sel1);
  // raw synchronised assertion, ahead of the debounce, pulls released pairs high
  wire [NUM_PAIRS-1:0] assert_seen = ({NUM_PAIRS{~req_s_r[0]}} & sel0) |
    ({NUM_PAIRS{~req_s_r[1]}} & sel1);
  reg [NUM_PAIRS-1:0] stopped_r;
  reg [NUM_PAIRS-1:0] stopped_nxt;

  always @* begin
    stopped_nxt = stopped_r;
    if (ref_rise) begin
      // halt right after the rising transition so true parks high
      stopped_nxt = stopped_r | stop_want;
    end else if (ref_fall) begin
      // resume on the falling edge, the next natural move from high
      stopped_nxt = stopped_r & stop_want;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      stopped_r <= {NUM_PAIRS{1'b0}};
      o_pair_true_out <= {NUM_PAIRS{1'b0}};
      o_pair_comp_out <= {NUM_PAIRS{1'b1}};
      o_pair_output_oe <= {NUM_PAIRS{1'b1}};
    end else begin
      stopped_r <= stopped_nxt;
      o_pair_true_out <= stopped_nxt | ({NUM_PAIRS{ref_s_r}} & ~stopped_nxt);
      o_pair_comp_out <= ~stopped_nxt & {NUM_PAIRS{~ref_s_r}};
      o_pair_output_oe <= ~(stopped_nxt & {NUM_PAIRS{drive_mode}} & ~assert_seen);
    end
  end

endmodule // ckg_core

// File: core/ckg_regs.vh
// register map, reset values and timing constants of the clock gating block
`ifndef CKG_REGS_VH
`define CKG_REGS_VH

// =============================================================
// serial port addressing
`define CKG_SLV_ADDR_WR 8'hd2
`define CKG_SLV_ADDR_RD 8'hd3
`define CKG_CMD_BYTE_BIT 7
`define CKG_CMD_CS_HI 6
`define CKG_CMD_CS_LO 5
`define CKG_CMD_IDX_HI 4
`define CKG_CMD_IDX_LO 0
`define CKG_CMD_CS_VAL 2'h0
`define CKG_BLK_COUNT 8'h08

// =============================================================
// register offsets
`define CKG_OFS_CTRL0 5'h00
`define CKG_OFS_CTRL1 5'h01
`define CKG_OFS_CTRL2 5'h02
`define CKG_OFS_CTRL3 5'h03
`define CKG_OFS_STOPSEL4 5'h04
`define CKG_OFS_STOPSEL5 5'h05
`define CKG_OFS_CTRL6 5'h06
`define CKG_OFS_MAKER_ID 5'h07

// =============================================================
// reset values
`define CKG_RST_CTRL0 8'hff
`define CKG_RST_CTRL1 8'hff
`define CKG_RST_CTRL2 8'hff
`define CKG_RST_CTRL3 8'h00
`define CKG_RST_STOPSEL4 8'h00
`define CKG_RST_STOPSEL5 8'h00
`define CKG_RST_CTRL6 8'h00
// arbitrary identification value
`define CKG_RST_MAKER_ID 8'h5a

// =============================================================
// field positions
`define CKG_DRIVE_MODE_BIT 0

// =============================================================
// timing
`define CKG_CLK_MHZ 40
`define CKG_HZ_RELEASE_NS 10

`endif

// File: dv/ckg_host.sv
// two-wire bus controller model that drives the serial port of the core
module ckg_host (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // quarter bit: the core needs each scl phase to last at least 4 clocks
  task q;
    repeat (5) @(negedge i_clk);
  endtask
  // sda moves while scl is high only to frame a transfer
  task start;
    q;
    o_sda_low = 1'b0;
    q;
    o_scl = 1'b1;
    q;
    o_sda_low = 1'b1;
    q;
    o_scl = 1'b0;
  endtask
  task stop;
    q;
    o_sda_low = 1'b1;
    q;
    o_scl = 1'b1;
    q;
    o_sda_low = 1'b0;
    q;
  endtask
  // msb first, ninth slot is the acknowledge
  task xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      q;
      o_sda_low = !tx[i];
      q;
      o_scl = 1'b1;
      q;
      q;
      rx[i] = i_sda;
      o_scl = 1'b0;
    end
  endtask
endmodule // ckg_host

// File: dv/ckg_core_monitor.sv
// port level assertions for the clock gating core
`include "ckg_regs.vh"
module ckg_core_monitor #(
  parameter NUM_PAIRS = 8
) (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire i_scl,
  input wire o_sda_out,
  input wire o_sda_oe,
  input wire [1:0] i_output_stop_request_n,
  input wire [NUM_PAIRS-1:0] o_pair_true_out,
  input wire [NUM_PAIRS-1:0] o_pair_comp_out,
  input wire [NUM_PAIRS-1:0] o_pair_output_oe,
  input wire [7:0] o_control_byte_zero,
  input wire [7:0] o_control_byte_six
);
  // =============================================================
  // helper counters: quiet time of the request pins, age of last toggle
  int quiet_age;
  int tog_age;
  logic t0_r;
  always @(posedge i_ref_clk) begin
    t0_r <= o_pair_true_out[0];
    quiet_age <= (i_sys_rst || |i_output_stop_request_n) ? 0 : quiet_age + 1;
    tog_age <= (i_sys_rst || t0_r != o_pair_true_out[0]) ? 0 : tog_age + 1;
  end
  // =============================================================
  // properties
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_parked_hz;
    !o_pair_output_oe[0] && i_output_stop_request_n == 2'b00;
  endsequence
  sequence s_flat_driven;
    $stable(o_pair_true_out[0]) && o_pair_output_oe[0];
  endsequence
  property p_sda_out_zero; o_sda_out == 1'b0; endproperty
  a_sda_out_zero: assert property (p_sda_out_zero) else $error("sda value high");
  property p_sda_move; !$stable(o_sda_oe) |-> !i_scl && !$past(i_scl, 2); endproperty
  a_sda_move: assert property (p_sda_move) else $error("sda moved, scl high");
  property p_defaults;
    $fell(i_sys_rst) |-> {o_control_byte_zero, o_control_byte_six} == 16'hff00;
  endproperty
  a_defaults: assert property (p_defaults) else $error("bad reset value");
  property p_comp; o_pair_output_oe[0] |-> o_pair_comp_out[0] != o_pair_true_out[0]; endproperty
  a_comp: assert property (p_comp) else $error("pair not complementary");
  property p_park; s_flat_driven [*8] |-> o_pair_true_out[0] && !o_pair_comp_out[0]; endproperty
  a_park: assert property (p_park) else $error("bad parked level");
  property p_oe_drop; $fell(o_pair_output_oe[0]) |-> quiet_age < 40; endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("release without request");
  property p_oe_rise; s_parked_hz [*5] |=> o_pair_output_oe[0]; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive not restored");
  property p_restart; quiet_age > 56 |-> tog_age < 6; endproperty
  a_restart: assert property (p_restart) else $error("late restart");
  property p_together;
    !$stable(o_pair_true_out[0]) && !$stable(o_pair_true_out[1]) |->
      o_pair_true_out[0] == o_pair_true_out[1];
  endproperty
  a_together: assert property (p_together) else $error("pairs out of step");
endmodule // ckg_core_monitor

bind ckg_core ckg_core_monitor #(.NUM_PAIRS(NUM_PAIRS)) ckg_core_monitor_inst (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .i_output_stop_request_n(i_output_stop_request_n),
  .o_pair_true_out(o_pair_true_out), .o_pair_comp_out(o_pair_comp_out),
  .o_pair_output_oe(o_pair_output_oe), .o_control_byte_zero(o_control_byte_zero),
  .o_control_byte_six(o_control_byte_six));

// File: dv/ckg_core_tb.sv
// self-checking bench for the clock gating core
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module ckg_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ref_clk = 1'b0;
  logic [1:0] req = 2'b00;
  logic scl, sda_low, sda_out, sda_oe;
  logic [3:0] tru, cmp, oe;
  logic [7:0] c0, c1, c2, c3, c6;
  logic [7:0] mdl [8] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5a};
  logic [8:0] r;
  logic [7:0] d;
  int error_cnt = 0;
  int checks = 0;
  int j;
  // open drain line with pull-up
  wire sda = !(sda_low || (sda_oe && !sda_out));
  initial forever #12.5 clk = !clk;
  // reference clock runs free, phase unrelated to clk
  initial begin
    #37;
    forever #100 ref_clk = !ref_clk;
  end
  ckg_core #(.NUM_PAIRS(4)) ckg_core_inst (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .i_output_stop_request_n(req), .i_pair_ref_edge_clock(ref_clk),
    .o_pair_true_out(tru), .o_pair_comp_out(cmp), .o_pair_output_oe(oe),
    .o_control_byte_zero(c0), .o_control_byte_one(c1), .o_control_byte_two(c2),
    .o_control_byte_three(c3), .o_control_byte_six(c6));
  ckg_host ckg_host_inst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  // =============================================================
  // bus helpers and expectation
  function automatic logic [7:0] keep(input logic [4:0] i, input logic [7:0] o, v);
    return (i >= 5'h07) ? o : v;
  endfunction
  task snd(input logic [7:0] b, input logic ak);
    ckg_host_inst.xfer({b, 1'b1}, r);
    `CHK("ack", ak, !r[0])
  endtask
  task rcv(input logic last);
    ckg_host_inst.xfer({8'hff, last}, r);
    d = r[8:1];
  endtask
  task hdr(input logic [7:0] cmd);
    ckg_host_inst.start;
    snd(8'hd2, 1'b1);
    snd(cmd, 1'b1);
  endtask
  task wr(input logic [4:0] i, input logic [7:0] v);
    hdr({3'b100, i});
    snd(v, 1'b1);
    ckg_host_inst.stop;
    mdl[i] = keep(i, mdl[i], v);
  endtask
  task rd(input logic [4:0] i);
    hdr({3'b100, i});
    ckg_host_inst.start;
    snd(8'hd3, 1'b1);
    rcv(1'b1);
    ckg_host_inst.stop;
  endtask
  task wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // =============================================================
  // main sequence
  initial begin
    void'($urandom(54419));
    wait_clk(10);
    rst = 1'b0;
    wait_clk(4);
    for (int i = 0; i < 8; i++) begin
      rd(5'(i));
      `CHK("reg", mdl[i], d)
    end
    $display("test 1 done");
    for (int i = 0; i < 10; i++) begin
      j = (i < 2) ? 7 : $urandom % 7;
      wr(5'(j), 8'($urandom));
      rd(5'(j));
      `CHK("byte", mdl[j], d)
    end
    `CHK("port6", mdl[6], c6)
    $display("test 2 done");
    // block write cut short after three bytes
    hdr(8'h00);
    snd(8'h08, 1'b1);
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      snd(d, 1'b1);
      mdl[i] = d;
    end
    ckg_host_inst.stop;
    hdr(8'h00);
    ckg_host_inst.start;
    snd(8'hd3, 1'b1);
    rcv(1'b0);
    `CHK("count", 8'h08, d)
    for (int i = 0; i < 8; i++) begin
      rcv(i == 7);
      `CHK("blk", mdl[i], d)
    end
    ckg_host_inst.stop;
    `CHK("port0", mdl[0], c0)
    `CHK("port1", mdl[1], c1)
    `CHK("port2", mdl[2], c2)
    `CHK("port3", mdl[3], c3)
    $display("test 3 done");
    ckg_host_inst.start;
    snd(8'hd4, 1'b0);
    ckg_host_inst.stop;
    hdr(8'ha0 ^ 8'ha0 ^ 8'h80);
    ckg_host_inst.stop;
    ckg_host_inst.start;
    snd(8'hd2, 1'b1);
    snd(8'ha0, 1'b0);
    ckg_host_inst.stop;
    $display("test 4 done");
    // pair 0 on request 0, pair 1 on request 1; configured before use
    wr(5'h04, 8'h01);
    wr(5'h05, 8'h02);
    for (int m = 0; m < 2; m++) begin
      wr(5'h06, 8'(m));
      wait_clk($urandom % 7);
      req = 2'b01;
      wait_clk(40);
      `CHK("oe", m == 0, oe[0])
      if (m == 0) `CHK("park", 2'b10, {tru[0], cmp[0]})
      d[0] = tru[1];
      wait_clk(4);
      `CHK("run", !d[0], tru[1])
      req = 2'b00;
      for (int k = 0; k < 5 && oe[0] !== 1'b1; k++) wait_clk(1);
      `CHK("drive", 1'b1, oe[0])
      wait_clk(48);
      `CHK("sync", tru[1], tru[0])
    end
    // a one clock pulse must not stop anything
    req = 2'b01;
    wait_clk(1);
    req = 2'b00;
    wait_clk(12);
    d[0] = tru[0];
    wait_clk(4);
    `CHK("pulse", !d[0], tru[0])
    $display("test 5 done");
    end_sim;
  end
endmodule // ckg_core_tb
